//--- brm_consts.vh
`ifndef BRM_CONSTS_VH
`define BRM_CONSTS_VH
// ******************************
// map layout
// ******************************
`define BRM_ADDR_W 16
`define BRM_DATA_W 8
`define BRM_ADDR_LO 16'h0000
`define BRM_ADDR_HI 16'h0e3c
`define BRM_UPDATE_ADDR 16'h0005
`define BRM_UPDATE_VAL 8'h01
`define BRM_SEQ_LO 16'h0e10
`define BRM_SEQ_HI 16'h0e3c
// ******************************
// implemented window of storage
// ******************************
`define BRM_STORE_BASE 16'h0100
`define BRM_STORE_N 16
`define BRM_STORE_IDX_W 4
`define BRM_ROSTAT_ADDR 16'h0d00
`define BRM_SEQ_N 4
// ******************************
// option codes
// ******************************
`define BRM_OPT_W 4
`define BRM_OPT_LIVE 0
`define BRM_OPT_AUTO 1
`define BRM_OPT_RO 2
`define BRM_OPT_EXCL 3
`define BRM_RESET_VAL 8'h00
`endif

//--- brm_cell.v
`timescale 1ns/1ps
`default_nettype none
`include "brm_consts.vh"
// one byte register with buffered and active copies
module brm_cell #(
    parameter LIVE = 0,
    parameter AUTO = 0
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst_b,
    // write port
    input wire i_wr,
    input wire [7:0] i_wdata,
    input wire i_update,
    input wire i_done,
    // copies
    output reg [7:0] o_buf,
    output reg [7:0] o_act
);
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_buf <= `BRM_RESET_VAL;
            o_act <= `BRM_RESET_VAL;
        end else begin
            if (i_wr)
                o_buf <= i_wdata;
            if (LIVE != 0 && i_wr)
                o_act <= i_wdata;
            else if (LIVE == 0 && i_update)
                o_act <= i_wr ? i_wdata : o_buf;
            else if (AUTO != 0 && i_done) begin
                o_act <= `BRM_RESET_VAL;
                o_buf <= i_wr ? i_wdata : `BRM_RESET_VAL;
            end
        end
    end
endmodule // brm_cell
`default_nettype wire

//--- brm_regmap.v
`timescale 1ns/1ps
`default_nettype none
`include "brm_consts.vh"
module brm_regmap #(
    parameter N = `BRM_STORE_N,
    parameter [N-1:0] LIVE_MASK = 16'h000f,
    parameter [N-1:0] AUTO_MASK = 16'h0010,
    parameter [N-1:0] EXCL_MASK = 16'hc000
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst_b,
    // serial port byte access (address already assembled high byte first)
    input wire i_sp_wr,
    input wire i_sp_rd,
    input wire [15:0] i_sp_addr,
    input wire [7:0] i_sp_wdata,
    // eeprom controller access
    input wire i_ee_busy,
    input wire i_ee_wr,
    input wire i_ee_rd,
    input wire [15:0] i_ee_addr,
    input wire [7:0] i_ee_wdata,
    // action completion for autoclear bytes
    input wire [N-1:0] i_action_done,
    // read-only status fed by the device
    input wire [7:0] i_status,
    // read answers
    output reg [7:0] o_sp_rdata,
    output reg [7:0] o_ee_rdata,
    // active copies for functional logic and sequence bytes
    output reg [8*N-1:0] o_active,
    output reg [8*`BRM_SEQ_N-1:0] o_seq
);
    // ******************************
    // local sizes
    // ******************************
    // the exists flag sits just above the option bits
    localparam EXIST = `BRM_OPT_W;
    localparam CLS_W = `BRM_OPT_W + 1;
    localparam [CLS_W-1:0] CLS_NONE = {CLS_W{1'b0}};
    localparam [CLS_W-1:0] CLS_PLAIN = {1'b1, {`BRM_OPT_W{1'b0}}};
    // ******************************
    // decode
    // ******************************
    // store window test, shared by both access ports
    function in_store;
        input [15:0] a;
        reg [15:0] off;
        begin
            off = a - `BRM_STORE_BASE;
            in_store = (a >= `BRM_STORE_BASE) && (off < N);
        end
    endfunction

    // sequence window test, shared by both access ports
    function in_seq;
        input [15:0] a;
        reg [15:0] sq;
        begin
            sq = a - `BRM_SEQ_LO;
            in_seq = (a >= `BRM_SEQ_LO) && (sq < `BRM_SEQ_N);
        end
    endfunction

    // class of an address: bit per option, plus exists
    function [CLS_W-1:0] classify;
        input [15:0] a;
        reg [15:0] off;
        begin
            off = a - `BRM_STORE_BASE;
            classify = CLS_NONE;
            if (a > `BRM_ADDR_HI) begin
                classify = CLS_NONE;
            end else if (a == `BRM_UPDATE_ADDR) begin
                // the trigger exists but holds nothing, so it reads back zero
                classify = CLS_PLAIN;
            end else if (a == `BRM_ROSTAT_ADDR) begin
                classify = CLS_PLAIN;
                classify[`BRM_OPT_RO] = 1'b1;
            end else if (in_seq(a)) begin
                classify = CLS_PLAIN;
            end else if (in_store(a)) begin
                classify = CLS_PLAIN;
                classify[`BRM_OPT_LIVE] = LIVE_MASK[off[`BRM_STORE_IDX_W-1:0]];
                classify[`BRM_OPT_AUTO] = AUTO_MASK[off[`BRM_STORE_IDX_W-1:0]];
                classify[`BRM_OPT_EXCL] = EXCL_MASK[off[`BRM_STORE_IDX_W-1:0]];
            end
        end
    endfunction

    wire [CLS_W-1:0] sp_cls = classify(i_sp_addr);
    wire [CLS_W-1:0] ee_cls = classify(i_ee_addr);
    wire [15:0] sp_off = i_sp_addr - `BRM_STORE_BASE;
    wire [15:0] ee_off = i_ee_addr - `BRM_STORE_BASE;
    wire sp_is_store = in_store(i_sp_addr);
    wire ee_is_store = in_store(i_ee_addr);

    // ******************************
    // access rights
    // ******************************
    // most restrictive wins: exists, read-only and exclusion gate; live and autoclear do not
    // serial locked out while eeprom busy, except reads of the read-only status
    wire sp_rd_ok = sp_cls[EXIST] && (!i_ee_busy || sp_cls[`BRM_OPT_RO]);
    wire sp_wr_ok = sp_cls[EXIST] && !i_ee_busy && !sp_cls[`BRM_OPT_RO];
    wire ee_ok = ee_cls[EXIST] && i_ee_busy && !ee_cls[`BRM_OPT_RO] && !ee_cls[`BRM_OPT_EXCL];

    // update trigger detect
    // any other value written to the trigger is dropped, never stored
    wire update = i_sp_wr && sp_wr_ok && i_sp_addr == `BRM_UPDATE_ADDR && i_sp_wdata == `BRM_UPDATE_VAL;

    // ******************************
    // storage
    // ******************************
    wire [8*N-1:0] buf_w;
    wire [8*N-1:0] act_w;
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_cell
            wire sp_hit = i_sp_wr && sp_wr_ok && sp_is_store && sp_off[`BRM_STORE_IDX_W-1:0] == g;
            wire ee_hit = ee_ok && i_ee_wr && ee_is_store && ee_off[`BRM_STORE_IDX_W-1:0] == g;
            brm_cell #(.LIVE(LIVE_MASK[g]), .AUTO(AUTO_MASK[g])) u_cell (
                .i_ref_clk(i_ref_clk),
                .i_rst_b(i_rst_b),
                .i_wr(sp_hit | ee_hit),
                .i_wdata(ee_hit ? i_ee_wdata : i_sp_wdata),
                .i_update(update),
                .i_done(i_action_done[g]),
                .o_buf(buf_w[8*g+7:8*g]),
                .o_act(act_w[8*g+7:8*g])
            );
        end
    endgenerate

    // sequence bytes: kept in their own byte order, index = address - base
    reg [8*`BRM_SEQ_N-1:0] seq_reg;
    wire [15:0] sp_sq = i_sp_addr - `BRM_SEQ_LO;
    wire [15:0] ee_sq = i_ee_addr - `BRM_SEQ_LO;
    wire sp_is_seq = in_seq(i_sp_addr);
    wire ee_is_seq = in_seq(i_ee_addr);
    integer k;
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seq_reg <= {(8*`BRM_SEQ_N){1'b0}};
        end else begin
            for (k = 0; k < `BRM_SEQ_N; k = k + 1) begin
                // sequence bytes stored whole, not a value
                if (sp_wr_ok && i_sp_wr && sp_is_seq && sp_sq == k)
                    seq_reg[8*k +: 8] <= i_sp_wdata;
                else if (ee_ok && i_ee_wr && ee_is_seq && ee_sq == k)
                    seq_reg[8*k +: 8] <= i_ee_wdata;
            end
        end
    end

    // ******************************
    // read side
    // ******************************
    // buffered copy read back; status goes through the same path
    function [7:0] rd_byte;
        input is_store;
        input is_seq;
        input [15:0] a;
        input [15:0] off;
        input [15:0] sq;
        begin
            rd_byte = 8'h00;
            if (a == `BRM_ROSTAT_ADDR)
                rd_byte = i_status;
            else if (is_seq)
                rd_byte = seq_reg[8*sq[1:0] +: 8];
            else if (is_store)
                rd_byte = buf_w[8*off[`BRM_STORE_IDX_W-1:0] +: 8];
        end
    endfunction

    wire [7:0] sp_rd_byte = rd_byte(sp_is_store, sp_is_seq, i_sp_addr, sp_off, sp_sq);
    wire [7:0] ee_rd_byte = rd_byte(ee_is_store, ee_is_seq, i_ee_addr, ee_off, ee_sq);

    // read answers stand one cycle, then drop back to zero
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_sp_rdata <= 8'h00;
            o_ee_rdata <= 8'h00;
        end else begin
            o_sp_rdata <= (i_sp_rd && sp_rd_ok) ? sp_rd_byte : 8'h00;
            o_ee_rdata <= (i_ee_rd && ee_ok) ? ee_rd_byte : 8'h00;
        end
    end

    // ******************************
    // copies to functional logic
    // ******************************
    // one register stage so every output leaves from a flip-flop
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_active <= {(8*N){1'b0}};
            o_seq <= {(8*`BRM_SEQ_N){1'b0}};
        end else begin
            // byte g holds bits 8g up
            o_active <= act_w;
            o_seq <= seq_reg;
        end
    end
endmodule // brm_regmap
`default_nettype wire

//--- brm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// serial host, byte level
// ****
module brm_host_model (
    // clock and read answer
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    // requests
    output var logic o_wr,
    output var logic o_rd,
    output var logic [15:0] o_addr,
    output var logic [7:0] o_wdata
);
    initial {o_wr, o_rd, o_addr, o_wdata} = 26'h0;
    // address high first: it arrives here already whole
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        {o_wr, o_addr, o_wdata} = {1'b1, a, d};
        @(negedge i_ref_clk);
        // released lines show the inverse so a stale value never passes
        {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        @(negedge i_ref_clk);
        {o_rd, o_addr} = {1'b1, a};
        @(negedge i_ref_clk);
        q = i_rdata;
        {o_rd, o_addr} = {1'b0, ~a};
    endtask
endmodule // brm_host_model
`default_nettype wire

//--- brm_regmap_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module brm_regmap_sva #(parameter N = 16) (
    // clock and reset
    input wire logic i_ref_clk, i_rst_b,
    // requests
    input wire logic i_sp_wr, i_sp_rd, i_ee_busy, i_ee_wr, i_ee_rd,
    input wire logic [15:0] i_sp_addr, i_ee_addr,
    input wire logic [7:0] i_sp_wdata, i_ee_wdata, i_status,
    input wire logic [N-1:0] i_action_done,
    // answers
    input wire logic [7:0] o_sp_rdata, o_ee_rdata,
    input wire logic [8*N-1:0] o_active,
    input wire logic [31:0] o_seq
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic upd_hit = i_sp_wr && !i_ee_busy && i_sp_addr == 16'h0005 && i_sp_wdata == 8'h01;
    rd_idle_a: assert property (!i_sp_rd |=> o_sp_rdata == 8'h00)
        else $error("serial read data not zero when idle");
    ee_idle_a: assert property (!(i_ee_rd && i_ee_busy) |=> o_ee_rdata == 8'h00)
        else $error("eeprom read data without access");
    ro_read_a: assert property (i_sp_rd && i_sp_addr == 16'h0d00 |=> o_sp_rdata == $past(i_status))
        else $error("status read wrong");
    busy_deny_a: assert property (i_sp_rd && i_ee_busy && i_sp_addr != 16'h0d00 |=> o_sp_rdata == 8'h00)
        else $error("serial read while eeprom busy");
    ee_ro_a: assert property (i_ee_rd && i_ee_addr == 16'h0d00 |=> o_ee_rdata == 8'h00)
        else $error("eeprom read of status");
    ee_excl_a: assert property (i_ee_rd && i_ee_addr[15:1] == 15'h0087 |=> o_ee_rdata == 8'h00)
        else $error("eeprom read of excluded byte");
    unmapped_a: assert property (i_sp_rd && i_sp_addr > 16'h0e3c |=> o_sp_rdata == 8'h00)
        else $error("read beyond map not zero");
    live_take_a: assert property (i_sp_wr && !i_ee_busy && i_sp_addr == 16'h0100
        |-> ##2 o_active[7:0] == $past(i_sp_wdata, 2))
        else $error("live byte not in effect");
    auto_clear_a: assert property (i_action_done[4] && !upd_hit |-> ##2 o_active[39:32] == 8'h00)
        else $error("autoclear byte not cleared");
    act_hold_a: assert property ($changed(o_active[47:40]) |-> $past(upd_hit, 2))
        else $error("active byte moved without update");
endmodule // brm_regmap_sva
bind brm_regmap brm_regmap_sva #(.N(N)) u_sva (.*);
`default_nettype wire

//--- brm_regmap_bench.sv
`timescale 1ns/1ps
`default_nettype none
module brm_regmap_bench;
    logic i_ref_clk = 0, i_rst_b = 0, i_ee_busy = 0, i_ee_wr = 0, i_ee_rd = 0;
    logic [15:0] i_ee_addr = 0, i_action_done = 0, bad[5] = '{16'h0200, 16'h0e3c, 16'h0e3d, 16'hffff, 16'h0005};
    logic [7:0] i_ee_wdata = 0, i_status = 8'h9c, q;
    wire logic i_sp_wr, i_sp_rd;
    wire logic [15:0] i_sp_addr;
    wire logic [7:0] i_sp_wdata, o_sp_rdata, o_ee_rdata;
    wire logic [127:0] o_active;
    wire logic [31:0] o_seq;
    int err_total = 0, num_checks = 0;
    brm_host_model host (.i_ref_clk(i_ref_clk), .i_rdata(o_sp_rdata), .o_wr(i_sp_wr), .o_rd(i_sp_rd),
        .o_addr(i_sp_addr), .o_wdata(i_sp_wdata));
    brm_regmap dut (.*);
    initial forever #2.5 i_ref_clk = ~i_ref_clk;
    task chk(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task ee(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        {i_ee_wr, i_ee_rd, i_ee_addr, i_ee_wdata} = {w, !w, a, d};
        @(negedge i_ref_clk);
        {i_ee_wr, i_ee_rd, i_ee_addr} = {2'b00, ~a};
    endtask
    task wr2(input logic [15:0] a, input logic [7:0] d);
        host.wr(a, d);
        repeat (2) @(negedge i_ref_clk);
    endtask
    task close_out;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // watchdog: the tests need about 95 cycles
    initial begin
        #20000;
        err_total++;
        close_out;
    end
    initial begin
        repeat (16) @(negedge i_ref_clk);
        i_rst_b = 1;
        host.rd(16'h0100, q); chk("reset buffered", q, 0);
        chk("reset active", o_active[47:32], 0);
        host.wr(16'h0105, 8'h5a); host.wr(16'h0106, 8'h34); host.wr(16'h0107, 8'h12);
        wr2(16'h0005, 8'h02); chk("held", o_active[55:40], 0);
        wr2(16'h0005, 8'h01); chk("update", o_active[47:40], 8'h5a);
        chk("pair", o_active[63:48], 16'h1234);
        wr2(16'h0100, 8'ha5); chk("live", o_active[7:0], 8'ha5);
        host.wr(16'h0104, 8'h01); wr2(16'h0005, 8'h01); chk("auto set", o_active[39:32], 8'h01);
        i_action_done = 16'h0010;
        @(negedge i_ref_clk) i_action_done = 0;
        repeat (2) @(negedge i_ref_clk); chk("auto clear", o_active[39:32], 0);
        foreach (bad[i]) begin
            host.wr(bad[i], 8'h77); host.rd(bad[i], q); chk("denied", q, 0);
        end
        host.wr(16'h0d00, 8'hff); host.rd(16'h0d00, q); chk("status", q, 8'h9c);
        host.wr(16'h0e13, 8'h3c); host.rd(16'h0e13, q); chk("sequence", q, 8'h3c);
        chk("sequence out", o_seq[31:24], 8'h3c);
        i_ee_busy = 1;
        ee(1, 16'h0108, 8'h66); ee(0, 16'h0108, 0); chk("ee read", o_ee_rdata, 8'h66);
        host.wr(16'h0108, 8'h77); host.rd(16'h0105, q); chk("busy read", q, 0);
        host.rd(16'h0d00, q); chk("busy status", q, 8'h9c);
        ee(0, 16'h0d00, 0); chk("ee status", o_ee_rdata, 0);
        ee(1, 16'h010e, 8'h11); ee(0, 16'h010e, 0); chk("ee excluded", o_ee_rdata, 0);
        i_ee_busy = 0;
        host.rd(16'h0108, q); chk("ee owned", q, 8'h66);
        host.rd(16'h010e, q); chk("excluded kept", q, 0);
        ee(0, 16'h0108, 0); chk("ee idle", o_ee_rdata, 0);
        close_out;
    end
endmodule // brm_regmap_bench
`default_nettype wire
